// ### eq_emul_pkg.sv
// Constants and carrier types for the emulated link equalization registers
package eq_emul_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_LINK_CTRL  = 8'h00;
  localparam logic [7:0] OFF_SPEED_CFG  = 8'h04;
  localparam logic [7:0] OFF_LC2_RP     = 8'h08;
  localparam logic [7:0] OFF_LC2_EP     = 8'h0c;
  localparam logic [7:0] OFF_LC3        = 8'h10;
  localparam logic [7:0] OFF_LANE_EQ    = 8'h14;
  localparam logic [7:0] OFF_ST16       = 8'h18;
  localparam logic [7:0] OFF_LINK_STAT  = 8'h1c;
  localparam logic [7:0] OFF_MARG_CAP   = 8'h20;
  localparam logic [7:0] OFF_MARG_CTL   = 8'h24;
  localparam logic [7:0] OFF_MARG_STAT  = 8'h28;
  localparam logic [7:0] OFF_CLR_CYC    = 8'h2c;
  localparam logic [7:0] OFF_IRQ_STAT   = 8'h30;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h34;

  // Field positions
  localparam int LCTL_DIS_BIT     = 0;
  localparam int LCTL_HR_BIT      = 1;
  localparam int LCTL_RETRAIN_BIT = 2;
  localparam int SPD_8G_BIT       = 2;
  localparam int SPD_16G_BIT      = 3;
  localparam int SPD_32G_BIT      = 4;
  localparam int BYP_DIS_BIT      = 8;
  localparam int LC3_PERF_EQ_BIT  = 0;
  localparam logic [15:0] LC3_WMASK = 16'hfe03;
  localparam int LSTAT_EQ8_LSB    = 4;
  localparam int LSTAT_DLL_BIT    = 13;

  // Speed encodings
  localparam logic [3:0] SPEED_8G   = 4'h3;
  localparam logic [3:0] SPEED_16G  = 4'h4;

  // Lane equalization encoding limits
  localparam logic [3:0] PRESET_MAX = 4'ha;
  localparam logic [2:0] HINT_MAX   = 3'h6;

  // Margining
  localparam logic [2:0] MTYPE_TIME      = 3'h3;
  localparam logic [7:0] MARGIN_HEALTHY  = 8'h80;

  // Reset values
  localparam logic [4:0]  SUPP_RST  = 5'h0f;
  localparam logic [15:0] LC2_RST   = 16'h0004;
  localparam logic [15:0] LANE_RST  = 16'h0000;
  localparam logic [15:0] MARG_RST  = 16'hff00;

  // Status-clear interval
  localparam int CLK_MHZ       = 125;
  localparam int CLR_TIME_NS   = 10000;
  localparam int CLR_CYCLES    = (CLR_TIME_NS * CLK_MHZ) / 1000;

  localparam int IRQ_W = 4;

  typedef struct packed {
    logic [3:0] comp_preset;
    logic       comp_skip_ordered_set;
    logic       enter_mod_comp;
    logic [2:0] tx_margin;
    logic       sel_deemph;
    logic       auto_spd_dis;
    logic       enter_comp;
    logic [3:0] target_speed;
  } lnk_ctl2_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       valid;
  } ahb_req_t;

endpackage

// ### eq_emul_regs.sv
// Emulated link equalization register bank with AHB-Lite slave
//
// Summary of operation
// RULE1 - Link-active rise sets 8G success bits
// RULE2 - Link-active rise sets 16G status bits
// RULE3 - Success bits set before link-active asserts
// RULE4 - Disable or hot-reset release clears bits
// RULE5 - 8G retrain with equalize clears 8G bits
// RULE6 - 16G+ retrain with equalize clears 16G bits
// RULE7 - Clear interval pollable, ends before link-up
// RULE8 - Both functions show identical success bits
// RULE9 - Current speed is minimum target speed
// RULE10 - Endpoint target speed writes need compliance bit
// RULE11 - Listed control fields ignored by hardware
// RULE12 - Hardware never sets 16G equalization request
// RULE13 - Lane equalization fields keep valid encodings
// RULE14 - Margining registers emulated, time margining
// RULE15 - Time margining returns healthy results
// RULE16 - Margining driver software field reads zero
// RULE17 - Clear interval from programmable reloaded counter
//
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module eq_emul_regs #(
  parameter int CNT_W = 16
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        LINK_UP,
  output logic             DLL_ACTIVE,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [3:0] min_speed(input logic [3:0] a, input logic [3:0] b);
    min_speed = (a < b) ? a : b;
  endfunction

  function automatic logic [3:0] keep_preset(input logic [3:0] nw, input logic [3:0] old);
    keep_preset = (nw <= eq_emul_pkg::PRESET_MAX) ? nw : old;
  endfunction

  function automatic logic [2:0] keep_hint(input logic [2:0] nw, input logic [2:0] old);
    keep_hint = (nw <= eq_emul_pkg::HINT_MAX) ? nw : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  eq_emul_pkg::ahb_req_t   dph_r;
  logic                    rd_done_r;
  logic [31:0]             rdata_r;
  logic                    dis_r;
  logic                    hr_r;
  logic                    dis_q_r;
  logic                    hr_q_r;
  logic                    link_s1_r;
  logic                    link_s2_r;
  logic [4:0]              supp_r;
  logic                    byp_r;
  eq_emul_pkg::lnk_ctl2_t  lc2_rp_r;
  eq_emul_pkg::lnk_ctl2_t  lc2_ep_r;
  logic [15:0]             lc3_r;
  logic [15:0]             lane_r;
  logic [15:0]             mctl_r;
  logic [15:0]             mstat_r;
  logic [CNT_W-1:0]        clr_load_r;
  logic [CNT_W-1:0]        cnt_r;
  logic [3:0]              eq8_r;
  logic [3:0]              eq16_r;
  logic                    up_pend_r;
  logic                    dll_r;
  logic                    rt_q_r;
  logic [eq_emul_pkg::IRQ_W-1:0] irq_st_r;
  logic [eq_emul_pkg::IRQ_W-1:0] irq_mask_r;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire logic       addr_take = HSEL & HREADY & HTRANS[1];
  wire logic       wr        = dph_r.valid & dph_r.write;
  wire logic       rd_pend   = dph_r.valid & ~dph_r.write & ~rd_done_r;
  wire logic [7:0] wa        = dph_r.addr;
  wire logic       wr_lctl   = wr & (wa == eq_emul_pkg::OFF_LINK_CTRL);
  wire logic       wr_spd    = wr & (wa == eq_emul_pkg::OFF_SPEED_CFG);
  wire logic       wr_lc2rp  = wr & (wa == eq_emul_pkg::OFF_LC2_RP);
  wire logic       wr_lc2ep  = wr & (wa == eq_emul_pkg::OFF_LC2_EP);
  wire logic       wr_lc3    = wr & (wa == eq_emul_pkg::OFF_LC3);
  wire logic       wr_lane   = wr & (wa == eq_emul_pkg::OFF_LANE_EQ);
  wire logic       wr_mctl   = wr & (wa == eq_emul_pkg::OFF_MARG_CTL);
  wire logic       wr_clr    = wr & (wa == eq_emul_pkg::OFF_CLR_CYC);
  wire logic       wr_ist    = wr & (wa == eq_emul_pkg::OFF_IRQ_STAT);
  wire logic       wr_imsk   = wr & (wa == eq_emul_pkg::OFF_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Link emulation events
  // RULE9 minimum target speed
  wire logic [3:0] cur_speed = min_speed(lc2_rp_r.target_speed, lc2_ep_r.target_speed);
  wire logic no32  = ~supp_r[eq_emul_pkg::SPD_32G_BIT] | byp_r;
  wire logic c8    = supp_r[eq_emul_pkg::SPD_8G_BIT] & no32;
  wire logic c16   = supp_r[eq_emul_pkg::SPD_16G_BIT] & no32;
  wire logic dis_fall = dis_q_r & ~dis_r;
  wire logic hr_fall  = hr_q_r & ~hr_r;
  wire logic retrain  = wr_lctl & HWDATA[eq_emul_pkg::LCTL_RETRAIN_BIT];
  wire logic perf_eq  = lc3_r[eq_emul_pkg::LC3_PERF_EQ_BIT];
  wire logic rt8      = retrain & perf_eq & (cur_speed == eq_emul_pkg::SPEED_8G);
  wire logic rt16     = retrain & perf_eq & (cur_speed >= eq_emul_pkg::SPEED_16G);
  wire logic clr_all  = dis_fall | hr_fall;
  wire logic clr_start = clr_all | rt8 | rt16;
  wire logic expire   = (cnt_r == CNT_W'(1));
  wire logic cnt_idle = (cnt_r == '0);
  wire logic link_ok  = link_s2_r & ~dis_r & ~hr_r;
  // RULE7 link-up waits for interval end
  wire logic rise     = link_ok & cnt_idle & ~clr_start & ~dll_r & ~up_pend_r;
  wire logic restore  = expire & dll_r;
  wire logic dll_nxt  = link_ok & (dll_r | up_pend_r);

  // RULE17 reload counter per event
  wire logic [CNT_W-1:0] cnt_nxt = clr_start ? clr_load_r :
                                   (cnt_idle ? cnt_r : cnt_r - CNT_W'(1));

  // RULE1 RULE4 RULE5 set and clear 8G bits
  wire logic [3:0] eq8_nxt  = (clr_all | rt8) ? 4'h0 :
                              ((rise | restore) & c8) ? 4'hf : eq8_r;
  // RULE2 RULE4 RULE6 set and clear 16G bits
  wire logic [3:0] eq16_nxt = (clr_all | rt16) ? 4'h0 :
                              ((rise | restore) & c16) ? 4'hf : eq16_r;

  // RULE5 RULE6 drop perform equalization after clear
  wire logic [15:0] lc3_nxt = wr_lc3 ? (HWDATA[15:0] & eq_emul_pkg::LC3_WMASK) :
                              rt_q_r ? (lc3_r & ~16'h0001) : lc3_r;

  // RULE10 endpoint target speed gated by compliance
  wire eq_emul_pkg::lnk_ctl2_t ep_w = HWDATA[15:0];
  wire logic ep_spd_ok = ep_w.enter_comp | lc2_ep_r.enter_comp;
  wire eq_emul_pkg::lnk_ctl2_t ep_nxt = wr_lc2ep ?
      {ep_w[15:4], (ep_spd_ok ? ep_w.target_speed : lc2_ep_r.target_speed)} : lc2_ep_r;

  // RULE13 reject reserved preset and hint codes
  wire logic [15:0] lane_nxt = wr_lane ?
      {1'b0, keep_hint(HWDATA[14:12], lane_r[14:12]),
       keep_preset(HWDATA[11:8], lane_r[11:8]), 1'b0,
       keep_hint(HWDATA[6:4], lane_r[6:4]), keep_preset(HWDATA[3:0], lane_r[3:0])} : lane_r;

  // RULE14 RULE15 margining command response
  wire logic [7:0] marg_pay = (HWDATA[5:3] == eq_emul_pkg::MTYPE_TIME) ?
                              eq_emul_pkg::MARGIN_HEALTHY : HWDATA[15:8];
  wire logic [15:0] mstat_nxt = wr_mctl ? {marg_pay, 1'b0, HWDATA[6:0]} : mstat_r;

  wire logic [eq_emul_pkg::IRQ_W-1:0] irq_ev = {rise, expire, |(eq16_nxt & ~eq16_r),
                                                 |(eq8_nxt & ~eq8_r)};
  wire logic [eq_emul_pkg::IRQ_W-1:0] irq_clr = wr_ist ? HWDATA[eq_emul_pkg::IRQ_W-1:0] : '0;
  wire logic [eq_emul_pkg::IRQ_W-1:0] irq_nxt = (irq_st_r & ~irq_clr) | irq_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  // RULE8 single shared copy for both functions
  // RULE11 ignored fields only stored
  // RULE12 equalization request bit tied low
  // RULE16 driver software field reads zero
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (dph_r.addr)
      eq_emul_pkg::OFF_LINK_CTRL: rd_val = {30'h0, hr_r, dis_r};
      eq_emul_pkg::OFF_SPEED_CFG: rd_val = {23'h0, byp_r, 3'h0, supp_r};
      eq_emul_pkg::OFF_LC2_RP:    rd_val = {16'h0, lc2_rp_r};
      eq_emul_pkg::OFF_LC2_EP:    rd_val = {16'h0, lc2_ep_r};
      eq_emul_pkg::OFF_LC3:       rd_val = {16'h0, lc3_r};
      eq_emul_pkg::OFF_LANE_EQ:   rd_val = {16'h0, lane_r};
      eq_emul_pkg::OFF_ST16:      rd_val = {27'h0, 1'b0, eq16_r};
      eq_emul_pkg::OFF_LINK_STAT: rd_val = {18'h0, dll_r, 4'h0, 1'b0, eq8_r, cur_speed};
      eq_emul_pkg::OFF_MARG_CAP:  rd_val = 32'h0000_0000;
      eq_emul_pkg::OFF_MARG_CTL:  rd_val = {16'h0, mctl_r};
      eq_emul_pkg::OFF_MARG_STAT: rd_val = {16'h0, mstat_r};
      eq_emul_pkg::OFF_CLR_CYC:   rd_val = {{(32-CNT_W){1'b0}}, clr_load_r};
      eq_emul_pkg::OFF_IRQ_STAT:  rd_val = {28'h0, irq_st_r};
      eq_emul_pkg::OFF_IRQ_MASK:  rd_val = {28'h0, irq_mask_r};
      default:                    rd_val = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dph_r     <= '0;
      rd_done_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
    end else begin
      if (HREADY) begin
        dph_r <= '{addr: {HADDR[7:2], 2'b00}, write: HWRITE, valid: addr_take};
      end
      rd_done_r <= rd_pend;
      if (rd_pend) begin
        rdata_r <= rd_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dis_r      <= 1'b0;
      hr_r       <= 1'b0;
      supp_r     <= eq_emul_pkg::SUPP_RST;
      byp_r      <= 1'b0;
      lc2_rp_r   <= eq_emul_pkg::LC2_RST;
      lc2_ep_r   <= eq_emul_pkg::LC2_RST;
      lc3_r      <= 16'h0000;
      lane_r     <= eq_emul_pkg::LANE_RST;
      mctl_r     <= eq_emul_pkg::MARG_RST;
      mstat_r    <= 16'h0000;
      clr_load_r <= CNT_W'(eq_emul_pkg::CLR_CYCLES);
      irq_mask_r <= '0;
    end else begin
      if (wr_lctl) begin
        dis_r <= HWDATA[eq_emul_pkg::LCTL_DIS_BIT];
        hr_r  <= HWDATA[eq_emul_pkg::LCTL_HR_BIT];
      end
      if (wr_spd) begin
        supp_r <= HWDATA[4:0];
        byp_r  <= HWDATA[eq_emul_pkg::BYP_DIS_BIT];
      end
      if (wr_lc2rp) begin
        lc2_rp_r <= HWDATA[15:0];
      end
      lc2_ep_r <= ep_nxt;
      lc3_r    <= lc3_nxt;
      lane_r   <= lane_nxt;
      if (wr_mctl) begin
        mctl_r <= HWDATA[15:0];
      end
      mstat_r <= mstat_nxt;
      if (wr_clr) begin
        clr_load_r <= (HWDATA[CNT_W-1:0] == '0) ? CNT_W'(1) : HWDATA[CNT_W-1:0];
      end
      if (wr_imsk) begin
        irq_mask_r <= HWDATA[eq_emul_pkg::IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link emulation state
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      dis_q_r   <= 1'b0;
      hr_q_r    <= 1'b0;
      link_s1_r <= 1'b0;
      link_s2_r <= 1'b0;
      cnt_r     <= '0;
      eq8_r     <= 4'h0;
      eq16_r    <= 4'h0;
      up_pend_r <= 1'b0;
      dll_r     <= 1'b0;
      rt_q_r    <= 1'b0;
      irq_st_r  <= '0;
    end else begin
      dis_q_r   <= dis_r;
      hr_q_r    <= hr_r;
      link_s1_r <= LINK_UP;
      link_s2_r <= link_s1_r;
      cnt_r     <= cnt_nxt;
      eq8_r     <= eq8_nxt;
      eq16_r    <= eq16_nxt;
      // RULE3 link-active one cycle after bits
      up_pend_r <= rise;
      dll_r     <= dll_nxt;
      rt_q_r    <= rt8 | rt16;
      irq_st_r  <= irq_nxt;
    end
  end

  assign HRDATA     = rdata_r;
  assign HREADYOUT  = ~rd_pend;
  assign HRESP      = 1'b0;
  assign DLL_ACTIVE = dll_r;
  assign IRQ        = |(irq_st_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_eq8_set;
    rise && c8 && !clr_all |=> eq8_r == 4'hf ##1 dll_r || !link_ok;
  endproperty
  a_eq8_set: assert property (p_eq8_set) else $error("8G bits not set on link rise"); // RULE1

  property p_eq16_set;
    rise && c16 && !clr_all |=> eq16_r == 4'hf;
  endproperty
  a_eq16_set: assert property (p_eq16_set) else $error("16G bits not set on link rise"); // RULE2

  property p_before;
    $rose(dll_r) && c8 |-> $past(eq8_r) == 4'hf;
  endproperty
  a_before: assert property (p_before) else $error("Link active before 8G bits"); // RULE3

  property p_rel_clr;
    clr_all |=> eq8_r == 4'h0 && eq16_r == 4'h0 && cnt_r == $past(clr_load_r);
  endproperty
  a_rel_clr: assert property (p_rel_clr) else $error("Release did not clear bits"); // RULE4

  property p_rt8;
    rt8 && !clr_all |=> eq8_r == 4'h0 ##1 !lc3_r[0] || $past(wr_lc3);
  endproperty
  a_rt8: assert property (p_rt8) else $error("8G retrain clear wrong"); // RULE5

  property p_rt16;
    rt16 && !clr_all |=> eq16_r == 4'h0 ##1 !lc3_r[0] || $past(wr_lc3);
  endproperty
  a_rt16: assert property (p_rt16) else $error("16G retrain clear wrong"); // RULE6

  property p_hold_down;
    !cnt_idle && !dll_r |=> !dll_r;
  endproperty
  a_hold_down: assert property (p_hold_down) else $error("Link up during clear"); // RULE7

  property p_cnt_run;
    !cnt_idle && !clr_start |=> cnt_r == $past(cnt_r) - CNT_W'(1);
  endproperty
  a_cnt_run: assert property (p_cnt_run) else $error("Clear counter stalled"); // RULE17

  property p_ep_gate;
    wr_lc2ep && !ep_w.enter_comp && !lc2_ep_r.enter_comp
      |=> $stable(lc2_ep_r.target_speed);
  endproperty
  a_ep_gate: assert property (p_ep_gate) else $error("EP speed changed"); // RULE10

  property p_lane_ok;
    lane_r[3:0] <= eq_emul_pkg::PRESET_MAX && lane_r[11:8] <= eq_emul_pkg::PRESET_MAX
      && lane_r[6:4] <= eq_emul_pkg::HINT_MAX && lane_r[14:12] <= eq_emul_pkg::HINT_MAX;
  endproperty
  a_lane_ok: assert property (p_lane_ok) else $error("Lane field out of range"); // RULE13

  property p_margin;
    wr_mctl && HWDATA[5:3] == eq_emul_pkg::MTYPE_TIME
      |=> mstat_r[15:8] == eq_emul_pkg::MARGIN_HEALTHY;
  endproperty
  a_margin: assert property (p_margin) else $error("Unhealthy margin result"); // RULE15

  property p_before16;
    $rose(dll_r) && c16 |-> $past(eq16_r) == 4'hf;
  endproperty
  a_before16: assert property (p_before16) else $error("Link active before 16G bits"); // RULE3

  property p_up_idle;
    $rose(dll_r) |-> $past(cnt_idle);
  endproperty
  a_up_idle: assert property (p_up_idle) else $error("Link active inside clear interval"); // RULE7

  property p_min_speed;
    cur_speed <= lc2_rp_r.target_speed && cur_speed <= lc2_ep_r.target_speed
      && (cur_speed == lc2_rp_r.target_speed || cur_speed == lc2_ep_r.target_speed);
  endproperty
  a_min_speed: assert property (p_min_speed) else $error("Current speed not minimum"); // RULE9

  c_link_up:  cover property (rise ##2 dll_r);
  c_retrain:  cover property (rt16 ##[1:40] restore);
  c_hot_rst:  cover property (hr_fall ##[1:40] expire);
  c_irq:      cover property (IRQ ##1 wr_ist);

endmodule

`default_nettype wire

// ### eq_link_partner.sv
// Behavioural far-side function driving the physical link indication
`timescale 1ns/1ps
`default_nettype none

module eq_link_partner (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic en,
  input  wire logic slow,
  output logic      link_up
);
  logic [7:0] wait_r;

  always_ff @(posedge clk) begin
    if (!rst_n || !en) begin
      wait_r  <= slow ? 8'h28 : 8'h04;
      link_up <= 1'b0;
    end else if (wait_r != 8'h00) begin
      wait_r <= wait_r - 8'h01;
    end else begin
      link_up <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// ### eq_emul_regs_test.sv
// Self-checking testbench for the emulated link equalization registers
`timescale 1ns/1ps
`default_nettype none

module eq_emul_regs_test;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        HSEL = 1'b0;
  logic [31:0] HADDR = 32'h0;
  logic [1:0]  HTRANS = 2'h0;
  logic        HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic        link_en = 1'b0;
  logic        link_slow = 1'b0;
  wire  logic  hready;
  wire  logic  [31:0] hrdata;
  wire  logic  hreadyout;
  wire  logic  hresp;
  logic        resp_bad = 1'b0;
  wire  logic  link_up;
  wire  logic  dll_active;
  wire  logic  irq;
  logic [31:0] rd;
  int          fail_count = 0;
  int          tests_run = 0;
  int          cycles = 0;

  assign hready = hreadyout;

  eq_emul_regs dut (
    .CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .LINK_UP(link_up),
    .DLL_ACTIVE(dll_active), .IRQ(irq)
  );

  eq_link_partner partner (
    .clk(CLK), .rst_n(RST_N), .en(link_en), .slow(link_slow), .link_up(link_up)
  );

  always #4 CLK = ~CLK;

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (hresp !== 1'b0) begin
      resp_bad <= 1'b1;
    end
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single AHB transfer, waits on hready in both phases
  task automatic xfer(input logic wr, input logic [7:0] off, input logic [31:0] wd);
    @(posedge CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, off};
    HWRITE <= wr;
    do @(posedge CLK); while (hreadyout !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    xfer(1'b1, off, d);
  endtask

  task automatic rdc(input logic [7:0] off, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, off, 32'h0);
    chk(rd & m, e);
  endtask

  task automatic wait_dll(input logic e);
    int n;
    n = 0;
    while (dll_active !== e && n < 300) begin
      @(posedge CLK);
      n++;
    end
    chk({31'h0, dll_active}, {31'h0, e});
  endtask

  task automatic relink(input int b);
    wr(eq_emul_pkg::OFF_LINK_CTRL, 32'h1 << b);
    wr(eq_emul_pkg::OFF_LINK_CTRL, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] cfg [3] = '{32'h1f, 32'h11f, 32'h07};
  logic [31:0] e8  [3] = '{32'h00, 32'hf0, 32'hf0};
  logic [31:0] e16 [3] = '{32'h0, 32'hf, 32'h0};

  initial begin
    repeat (5) @(posedge CLK);
    RST_N <= 1'b1;
    rdc(eq_emul_pkg::OFF_SPEED_CFG, 32'hffffffff, 32'h0f);
    rdc(eq_emul_pkg::OFF_LC2_EP, 32'hffffffff, 32'h0004);
    rdc(eq_emul_pkg::OFF_LC3, 32'hffffffff, 32'h0);
    rdc(eq_emul_pkg::OFF_LANE_EQ, 32'hffffffff, 32'h0);
    rdc(eq_emul_pkg::OFF_MARG_CAP, 32'hffffffff, 32'h0);
    rdc(eq_emul_pkg::OFF_MARG_CTL, 32'hffffffff, 32'hff00);
    rdc(eq_emul_pkg::OFF_CLR_CYC, 32'hffffffff, 32'h4e2);
    rdc(eq_emul_pkg::OFF_ST16, 32'hffffffff, 32'h0);
    wr(8'h3c, 32'hffffffff);
    rdc(8'h3c, 32'hffffffff, 32'h0);
    $display("test reset done");
    wr(eq_emul_pkg::OFF_CLR_CYC, 32'h10);
    link_en <= 1'b1;
    wait_dll(1'b1);
    rdc(eq_emul_pkg::OFF_LINK_STAT, 32'hffffffff, 32'h20f4);
    rdc(eq_emul_pkg::OFF_ST16, 32'hffffffff, 32'h0f);
    rdc(eq_emul_pkg::OFF_IRQ_STAT, 32'hf, 32'hb);
    chk({31'h0, irq}, 32'h0);
    wr(eq_emul_pkg::OFF_IRQ_MASK, 32'hf);
    #1 chk({31'h0, irq}, 32'h1);
    wr(eq_emul_pkg::OFF_IRQ_STAT, 32'hf);
    #1 chk({31'h0, irq}, 32'h0);
    rdc(eq_emul_pkg::OFF_IRQ_STAT, 32'hf, 32'h0);
    link_en <= 1'b0;
    wait_dll(1'b0);
    link_slow <= 1'b1;
    link_en <= 1'b1;
    wait_dll(1'b1);
    $display("test link done");
    for (int b = 0; b < 2; b++) begin
      relink(b);
      rdc(eq_emul_pkg::OFF_LINK_STAT, 32'h20f0, 32'h0);
      rdc(eq_emul_pkg::OFF_ST16, 32'hf, 32'h0);
      wait_dll(1'b1);
      rdc(eq_emul_pkg::OFF_LINK_STAT, 32'h20f0, 32'h20f0);
      rdc(eq_emul_pkg::OFF_IRQ_STAT, 32'h4, 32'h4);
    end
    $display("test clear done");
    for (int i = 0; i < 3; i++) begin
      wr(eq_emul_pkg::OFF_SPEED_CFG, cfg[i]);
      relink(0);
      wait_dll(1'b1);
      rdc(eq_emul_pkg::OFF_LINK_STAT, 32'hf0, e8[i]);
      rdc(eq_emul_pkg::OFF_ST16, 32'hf, e16[i]);
    end
    wr(eq_emul_pkg::OFF_SPEED_CFG, 32'h0f);
    relink(0);
    wait_dll(1'b1);
    $display("test speeds done");
    for (int t = 3; t < 5; t++) begin
      wr(eq_emul_pkg::OFF_LC2_RP, t);
      rdc(eq_emul_pkg::OFF_LINK_STAT, 32'hf, t);
      wr(eq_emul_pkg::OFF_LC3, 32'h1);
      wr(eq_emul_pkg::OFF_LINK_CTRL, 32'h4);
      rdc(eq_emul_pkg::OFF_LINK_STAT, 32'hf0, (t == 3) ? 32'h0 : 32'hf0);
      rdc(eq_emul_pkg::OFF_ST16, 32'hf, (t == 3) ? 32'hf : 32'h0);
      rdc(eq_emul_pkg::OFF_LC3, 32'h1, 32'h0);
      repeat (24) @(posedge CLK);
      rdc(eq_emul_pkg::OFF_LINK_STAT, 32'hf0, 32'hf0);
      rdc(eq_emul_pkg::OFF_ST16, 32'hf, 32'hf);
    end
    $display("test retrain done");
    wr(eq_emul_pkg::OFF_LC2_EP, 32'h3);
    rdc(eq_emul_pkg::OFF_LC2_EP, 32'hf, 32'h4);
    wr(eq_emul_pkg::OFF_LC2_EP, 32'h13);
    rdc(eq_emul_pkg::OFF_LC2_EP, 32'h1f, 32'h13);
    wr(eq_emul_pkg::OFF_LC2_RP, 32'hfff4);
    wr(eq_emul_pkg::OFF_LC3, 32'hfe02);
    rdc(eq_emul_pkg::OFF_LINK_STAT, 32'h21ff, 32'h20f3);
    rdc(eq_emul_pkg::OFF_ST16, 32'h1f, 32'hf);
    $display("test control done");
    wr(eq_emul_pkg::OFF_LANE_EQ, 32'h7b7b);
    rdc(eq_emul_pkg::OFF_LANE_EQ, 32'hffff, 32'h0);
    wr(eq_emul_pkg::OFF_LANE_EQ, 32'h6a6a);
    rdc(eq_emul_pkg::OFF_LANE_EQ, 32'hffff, 32'h6a6a);
    wr(eq_emul_pkg::OFF_MARG_CTL, 32'h1218);
    rdc(eq_emul_pkg::OFF_MARG_STAT, 32'hffff, 32'h8018);
    wr(eq_emul_pkg::OFF_MARG_CTL, 32'h1210);
    rdc(eq_emul_pkg::OFF_MARG_STAT, 32'hffff, 32'h1210);
    rdc(eq_emul_pkg::OFF_MARG_CTL, 32'hffff, 32'h1210);
    $display("test lane done");
    chk({31'h0, resp_bad}, 32'h0);
    test_done();
  end
endmodule

`default_nettype wire
